// >>> design/three_timer_group.sv
// core timer plus two auxiliary timers: mode, direction and run logic
module three_timer_group #(
    parameter int NUM_TIMERS = 3
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [1:0] global_prescale_field,
    input wire timer_group_pkg::timer_ctrl_t [NUM_TIMERS-1:0] ctrl,
    input wire timer_group_pkg::timer_pins_t [NUM_TIMERS-1:0] pins,
    input wire logic [NUM_TIMERS-1:0] count_wr,
    input wire logic [timer_group_pkg::TIMER_W-1:0] count_wdata,
    input wire logic [NUM_TIMERS-1:0] status_clr,
    output logic [NUM_TIMERS-1:0][timer_group_pkg::TIMER_W-1:0] count,
    output timer_group_pkg::timer_status_t [NUM_TIMERS-1:0] status,
    output logic [NUM_TIMERS-1:0] timer_irq
);
    // index 0 = core_timer, 1 = aux_timer_a, 2 = aux_timer_b
    // the index map above is fixed, so other counts cannot be served
    generate
        if (NUM_TIMERS != 3) begin : g_bad_count
            $error("three_timer_group needs exactly three timers");
        end
        if (timer_group_pkg::TIMER_W != 16) begin : g_bad_width
            $error("three_timer_group counts are 16 bits wide");
        end
        if (timer_group_pkg::GPS_BASE + 3 + 7 > 15) begin : g_bad_tap
            $error("prescale tap does not fit its 4-bit index");
        end
    endgenerate

    localparam int PS_W = 10;
    logic [PS_W-1:0] prescale_q;
    logic [PS_W-1:0] prescale_prev_q;
    logic [PS_W-1:0] ps_rise;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            prescale_q <= '0;
            prescale_prev_q <= '0;
        end else begin
            prescale_q <= prescale_q + 10'h001;
            prescale_prev_q <= prescale_q;
        end
    end

    // one-cycle rise of every chain bit, shared by all timers
    assign ps_rise = prescale_q & ~prescale_prev_q;

    logic core_run;
    assign core_run = ctrl[0].run;

    genvar g;
    generate
        for (g = 0; g < NUM_TIMERS; g++) begin : g_timer
            timer_group_pkg::timer_ctrl_t c;
            logic [1:0] ext_sync_q;
            logic [1:0] dir_sync_q;
            logic ext_q;
            logic dir_q;
            logic ext_rise;
            logic ext_fall;
            logic dir_rise;
            logic dir_fall;
            logic [3:0] tap;
            logic tick;
            logic run_sel;
            logic gate_ok;
            logic enc_mode;
            logic step;
            logic step_dir;
            logic enc_step;
            logic enc_dir;
            logic ext_dir_level;
            logic count_down;
            logic dir_q_state;
            logic dir_change_q;
            logic edge_q;
            logic irq_q;
            logic [timer_group_pkg::TIMER_W-1:0] count_q;
            logic [timer_group_pkg::TIMER_W-1:0] count_d;
            logic [timer_group_pkg::TIMER_W-1:0] count_inc;
            logic [timer_group_pkg::TIMER_W-1:0] count_dec;
            logic ext_edge;
            logic dir_edge;
            logic ext_tbl;
            logic dir_tbl;
            logic timer_step;
            logic gate_step;
            logic counter_hit;
            logic counter_step;
            logic enc_event;
            logic dir_flip;
            logic irq_event;
            timer_group_pkg::timer_status_t status_word;

            assign c = ctrl[g];

            // two-stage synchronizer, count or gate pin
            always_ff @(posedge mclk) begin
                if (sys_rst) begin
                    ext_sync_q <= 2'h0;
                    ext_q <= 1'b0;
                end else begin
                    ext_sync_q <= {ext_sync_q[0], pins[g].ext_in};
                    ext_q <= ext_sync_q[1];
                end
            end

            always_ff @(posedge mclk) begin
                if (sys_rst) begin
                    dir_sync_q <= 2'h0;
                    dir_q <= 1'b0;
                end else begin
                    dir_sync_q <= {dir_sync_q[0], pins[g].dir_in};
                    dir_q <= dir_sync_q[1];
                end
            end

            assign ext_rise = ext_sync_q[1] & ~ext_q;
            assign ext_fall = ~ext_sync_q[1] & ext_q;
            assign dir_rise = dir_sync_q[1] & ~dir_q;
            assign dir_fall = ~dir_sync_q[1] & dir_q;
            assign ext_edge = ext_rise | ext_fall;
            assign dir_edge = dir_rise | dir_fall;

            // table direction for each input edge, 1 = down
            assign ext_tbl = ext_rise ? dir_sync_q[1] : ~dir_sync_q[1];
            assign dir_tbl = dir_rise ? ~ext_sync_q[1] : ext_sync_q[1];

            assign tap = 4'(timer_group_pkg::GPS_BASE) + {2'h0, global_prescale_field}
                + {1'b0, c.input_select};
            // taps past the chain never fire, so the timer stands still there
            assign tick = (tap >= 4'(PS_W)) ? 1'b0 : ps_rise[tap];

            // remote run selection for aux timers
            assign run_sel = (g != 0 && c.remote_run) ? core_run : c.run;

            // gate polarity from mode bit 0
            assign gate_ok = c.mode[0] ? ext_sync_q[1] : ~ext_sync_q[1];

            assign enc_mode = (c.mode == timer_group_pkg::MODE_ENC_ROT)
                || (c.mode == timer_group_pkg::MODE_ENC_EDGE);

            always_comb begin
                enc_step = 1'b0;
                enc_dir = 1'b0;
                case (c.input_select[1:0])
                    timer_group_pkg::ENC_ONE: begin
                        if (ext_edge) begin
                            enc_step = 1'b1;
                            enc_dir = ext_tbl;
                        end
                    end
                    timer_group_pkg::ENC_DIR: begin
                        if (dir_edge) begin
                            enc_step = 1'b1;
                            enc_dir = dir_tbl;
                        end
                    end
                    timer_group_pkg::ENC_BOTH: begin
                        // edges on both pins in one cycle: only one step is taken
                        if (ext_edge) begin
                            enc_step = 1'b1;
                            enc_dir = ext_tbl;
                        end else if (dir_edge) begin
                            enc_step = 1'b1;
                            enc_dir = dir_tbl;
                        end
                    end
                    default: begin
                        enc_step = 1'b0;
                    end
                endcase
            end

            // direction: 1 = down; soft bit inverts ext level
            assign ext_dir_level = dir_sync_q[1];
            always_comb begin
                if (c.ext_dir_enable) begin
                    count_down = ext_dir_level ^ c.soft_dir;
                end else begin
                    count_down = c.soft_dir;
                end
            end

            // counter edge select; code 0 counts nothing
            always_comb begin
                case (c.input_select[1:0])
                    timer_group_pkg::EDGE_RISE: begin
                        counter_hit = ext_rise;
                    end
                    timer_group_pkg::EDGE_FALL: begin
                        counter_hit = ext_fall;
                    end
                    timer_group_pkg::EDGE_BOTH: begin
                        counter_hit = ext_edge;
                    end
                    default: begin
                        counter_hit = 1'b0;
                    end
                endcase
            end

            // the selected run bit gates every mode
            assign timer_step = run_sel & tick;
            assign gate_step = run_sel & gate_ok & tick;
            assign counter_step = run_sel & counter_hit;

            always_comb begin
                step = 1'b0;
                step_dir = count_down;
                case (c.mode)
                    timer_group_pkg::MODE_TIMER: begin
                        step = timer_step;
                    end
                    timer_group_pkg::MODE_GATE_LOW, timer_group_pkg::MODE_GATE_HIGH: begin
                        step = gate_step;
                    end
                    timer_group_pkg::MODE_COUNTER: begin
                        step = counter_step;
                    end
                    timer_group_pkg::MODE_ENC_ROT, timer_group_pkg::MODE_ENC_EDGE: begin
                        step = run_sel & enc_step;
                        step_dir = enc_dir ^ c.soft_dir;
                    end
                    default: step = 1'b0;
                endcase
            end

            assign count_inc = count_q + 16'h0001;
            assign count_dec = count_q - 16'h0001;

            // write wins over hardware step; the step is lost
            always_comb begin
                count_d = count_q;
                if (count_wr[g]) begin
                    count_d = count_wdata;
                end else if (step) begin
                    count_d = step_dir ? count_dec : count_inc;
                end
            end

            always_ff @(posedge mclk) begin
                if (sys_rst) begin
                    count_q <= timer_group_pkg::COUNT_RESET;
                end else begin
                    count_q <= count_d;
                end
            end

            // encoder event and reversal against last direction
            assign enc_event = enc_mode & step;
            assign dir_flip = enc_event & (step_dir != dir_q_state);

            // current encoder direction, up after reset
            always_ff @(posedge mclk) begin
                if (sys_rst) begin
                    dir_q_state <= 1'b0;
                end else if (enc_event) begin
                    dir_q_state <= step_dir;
                end
            end

            // sticky reversal flag; a set in the clear cycle wins
            always_ff @(posedge mclk) begin
                if (sys_rst) begin
                    dir_change_q <= 1'b0;
                end else if (dir_flip) begin
                    dir_change_q <= 1'b1;
                end else if (status_clr[g]) begin
                    dir_change_q <= 1'b0;
                end
            end

            // sticky count-edge flag, same priority as the reversal flag
            always_ff @(posedge mclk) begin
                if (sys_rst) begin
                    edge_q <= 1'b0;
                end else if (enc_event) begin
                    edge_q <= 1'b1;
                end else if (status_clr[g]) begin
                    edge_q <= 1'b0;
                end
            end

            // irq only from encoder events, never from a gate
            assign irq_event = ((c.mode == timer_group_pkg::MODE_ENC_EDGE) & enc_event)
                | ((c.mode == timer_group_pkg::MODE_ENC_ROT) & dir_flip);

            always_ff @(posedge mclk) begin
                if (sys_rst) begin
                    irq_q <= 1'b0;
                end else begin
                    irq_q <= irq_event;
                end
            end

            // no toggle latch or output pin on any aux timer
            assign count[g] = count_q;
            assign status_word.enc_dir = dir_q_state;
            assign status_word.dir_change = dir_change_q;
            assign status_word.count_edge = edge_q;
            assign status[g] = status_word;
            assign timer_irq[g] = irq_q;
        end
    endgenerate
endmodule // three_timer_group

// >>> design/timer_group_pkg.sv
// shared constants and types for the three-timer group mode logic
package timer_group_pkg;
    localparam int TIMER_W = 16;
    localparam logic [2:0] MODE_TIMER = 3'h0;
    localparam logic [2:0] MODE_COUNTER = 3'h1;
    localparam logic [2:0] MODE_GATE_LOW = 3'h2;
    localparam logic [2:0] MODE_GATE_HIGH = 3'h3;
    localparam logic [2:0] MODE_ENC_ROT = 3'h6;
    localparam logic [2:0] MODE_ENC_EDGE = 3'h7;
    // edge select in low bits of input_select (counter mode only)
    localparam logic [1:0] EDGE_NONE = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    // encoder select: 1 = count input only, 2 = dir input only, 3 = both
    localparam logic [1:0] ENC_ONE = 2'h1;
    localparam logic [1:0] ENC_DIR = 2'h2;
    localparam logic [1:0] ENC_BOTH = 2'h3;
    // prescale width: global 2 bits (2^(3+n) base), timer 3 bits (2^n)
    localparam int GPS_BASE = 2;
    localparam logic [TIMER_W-1:0] COUNT_RESET = 16'h0000;

    typedef struct packed {
        logic [2:0] mode;
        logic [2:0] input_select;
        logic run;
        logic soft_dir;
        logic ext_dir_enable;
        logic remote_run;
    } timer_ctrl_t;

    typedef struct packed {
        logic enc_dir;
        logic dir_change;
        logic count_edge;
    } timer_status_t;

    typedef struct packed {
        logic ext_in;
        logic dir_in;
    } timer_pins_t;
endpackage

// >>> verification/timer_group_asserts.sv
// concurrent checks on the timer group ports
module timer_group_asserts #(
    parameter int NUM_TIMERS = 3
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [1:0] global_prescale_field,
    input wire timer_group_pkg::timer_ctrl_t [NUM_TIMERS-1:0] ctrl,
    input wire timer_group_pkg::timer_pins_t [NUM_TIMERS-1:0] pins,
    input wire logic [NUM_TIMERS-1:0] count_wr,
    input wire logic [timer_group_pkg::TIMER_W-1:0] count_wdata,
    input wire logic [NUM_TIMERS-1:0] status_clr,
    input wire logic [NUM_TIMERS-1:0][timer_group_pkg::TIMER_W-1:0] count,
    input wire timer_group_pkg::timer_status_t [NUM_TIMERS-1:0] status,
    input wire logic [NUM_TIMERS-1:0] timer_irq
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge mclk);
    endclocking
    default disable iff (sys_rst);
    // five quiet cycles let a step already in the pin pipeline land
    sequence core_off_s;
        (!ctrl[0].run && !count_wr[0])[*5];
    endsequence
    sequence aux_off_s;
        (ctrl[1].remote_run && !ctrl[0].run && !count_wr[1])[*5];
    endsequence
    sequence gate_shut_s;
        (ctrl[1].mode == timer_group_pkg::MODE_GATE_LOW && pins[1].ext_in && !count_wr[1])[*5];
    endsequence
    write_load_a: assert property (count_wr[0] |=> count[0] == $past(count_wdata))
        else $error("count write not loaded");
    core_hold_a: assert property (core_off_s |=> $stable(count[0]))
        else $error("core moved while stopped");
    remote_hold_a: assert property (aux_off_s |=> $stable(count[1]))
        else $error("aux moved with core run low");
    gate_low_a: assert property (gate_shut_s |=> $stable(count[1]))
        else $error("aux moved with gate closed");
    no_irq_a: assert property (timer_irq[0] |-> $past(ctrl[0].mode[2:1]) == 2'h3)
        else $error("irq outside encoder modes");
    edge_irq_a: assert property (ctrl[0].mode == timer_group_pkg::MODE_ENC_EDGE
        && $changed(count[0]) && !$past(count_wr[0])
        |-> (##[0:1] timer_irq[0]) or ($past(timer_irq[0])))
        else $error("count edge without irq");
    rot_irq_a: assert property (timer_irq[0] && ctrl[0].mode == timer_group_pkg::MODE_ENC_ROT
        |-> ##[0:1] status[0].dir_change)
        else $error("rotation irq without change flag");
    dir_flag_a: assert property ($rose(status[0].dir_change) |-> $past(ctrl[0].mode[2:1]) == 2'h3)
        else $error("change flag outside encoder modes");
endmodule // timer_group_asserts

// >>> verification/quad_encoder_model.sv
// incremental encoder model for the core timer pins
module quad_encoder_model (
    input wire logic mclk,
    input wire logic step,
    input wire logic back,
    output timer_group_pkg::timer_pins_t pins
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] pos_q = 2'h0;
    always_ff @(posedge mclk) begin
        if (step) begin
            pos_q <= back ? pos_q - 2'h1 : pos_q + 2'h1;
        end
    end
    // gray order, one pin per step
    assign pins = {pos_q[1] ^ pos_q[0], pos_q[1]};
endmodule // quad_encoder_model

// >>> verification/three_timer_group_tb.sv
// self-checking bench for the three-timer group
module three_timer_group_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic [1:0] gps = 2'h0;
    timer_group_pkg::timer_ctrl_t [2:0] ctrl = '0;
    wire timer_group_pkg::timer_pins_t [2:0] pins;
    timer_group_pkg::timer_pins_t ap = '0;
    logic [2:0] wr = 3'h0;
    logic [15:0] wd = 16'h0000;
    logic [2:0] clr = 3'h0;
    logic step = 1'b0;
    logic back = 1'b0;
    logic [2:0][15:0] count;
    timer_group_pkg::timer_status_t [2:0] status;
    logic [2:0] irq;
    int err_count = 0;
    int tests_run = 0;
    int irqs = 0;
    assign pins[1] = ap;
    assign pins[2] = 2'h0;
    initial forever #10 mclk = ~mclk;
    always @(negedge mclk) if (irq[0] === 1'b1) irqs++;
    three_timer_group i_dut (.mclk(mclk), .sys_rst(sys_rst), .global_prescale_field(gps),
        .ctrl(ctrl), .pins(pins), .count_wr(wr), .count_wdata(wd), .status_clr(clr),
        .count(count), .status(status), .timer_irq(irq));
    quad_encoder_model i_enc (.mclk(mclk), .step(step), .back(back), .pins(pins[0]));
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", s, e, g);
        end
    endtask
    task automatic load(input int i, input logic [15:0] v);
        wr = 3'(1 << i);
        wd = v;
        cyc(1);
        wr = 3'h0;
        cyc(1);
    endtask
    task automatic span(input int i, output logic [15:0] d);
        logic [15:0] c0;
        c0 = count[i];
        cyc(64);
        d = count[i] - c0;
    endtask
    task automatic enc(input logic b, input int n);
        back = b;
        repeat (n) begin
            step = 1'b1;
            cyc(1);
            step = 1'b0;
            cyc(8);
        end
    endtask
    task automatic test_write();
        for (int i = 0; i < 3; i++) load(i, 16'hC0DE + 16'(i));
        cyc(1);
        for (int i = 0; i < 3; i++) chk("count", 16'hC0DE + 16'(i), count[i]);
        $display("write test done");
    endtask
    task automatic test_timer();
        logic [15:0] d;
        logic [15:0] e [3] = '{16'h0008, 16'hFFF8, 16'h0004};
        for (int k = 0; k < 3; k++) begin
            gps = 2'(k >> 1);
            ctrl[0] = '{mode: timer_group_pkg::MODE_TIMER, run: 1'b1, soft_dir: k == 1, default: 0};
            cyc(4);
            span(0, d);
            chk("timer steps", e[k], d);
        end
        ctrl[0] = '0;
        gps = 2'h0;
        $display("timer test done");
    endtask
    task automatic test_gate();
        logic [15:0] d;
        logic [3:0] r;
        logic [3:0] rows [6] = '{4'h4, 4'h0, 4'h8, 4'hC, 4'h6, 4'h7};
        for (int k = 0; k < 6; k++) begin
            r = rows[k];
            ap.ext_in = r[2];
            ctrl[0].run = r[0];
            ctrl[1] = '{mode: r[3] ? timer_group_pkg::MODE_GATE_LOW : timer_group_pkg::MODE_GATE_HIGH,
                run: !r[1], remote_run: r[1], default: 0};
            cyc(8);
            span(1, d);
            chk("gated steps", ((r[2] ^ r[3]) && (!r[1] || r[0])) ? 16'h0008 : 16'h0000, d);
        end
        ctrl = '0;
        $display("gate test done");
    endtask
    task automatic test_counter();
        logic [3:0] rows [5] = '{4'h0, 4'h4, 4'h8, 4'hC, 4'hF};
        logic [15:0] e [5] = '{16'h0000, 16'h0002, 16'h0002, 16'h0004, 16'hFFFC};
        for (int k = 0; k < 5; k++) begin
            ctrl[1] = '{mode: timer_group_pkg::MODE_COUNTER, input_select: {1'b0, rows[k][3:2]},
                run: 1'b1, ext_dir_enable: rows[k][1], default: 0};
            ap.dir_in = rows[k][0];
            cyc(8);
            load(1, 16'h0000);
            repeat (4) begin
                ap.ext_in = !ap.ext_in;
                cyc(8);
            end
            chk("edge count", e[k], count[1]);
        end
        ctrl = '0;
        $display("counter test done");
    endtask
    task automatic test_encoder();
        // external direction enable set; encoder modes ignore it
        ctrl[0] = '{mode: timer_group_pkg::MODE_ENC_EDGE, input_select: 3'h3, run: 1'b1,
            ext_dir_enable: 1'b1, default: 0};
        load(0, 16'h0000);
        enc(1'b0, 4);
        chk("enc count", 16'h0004, count[0]);
        chk("irq total", 16'h0004, 16'(irqs));
        chk("status", 16'h0001, 16'(status[0]));
        ctrl[0].mode = timer_group_pkg::MODE_ENC_ROT;
        enc(1'b1, 4);
        chk("enc count", 16'h0000, count[0]);
        chk("irq total", 16'h0005, 16'(irqs));
        chk("status", 16'h0007, 16'(status[0]));
        clr = 3'h1;
        cyc(1);
        clr = 3'h0;
        cyc(1);
        chk("status", 16'h0004, 16'(status[0]));
        // single-input resolution with the soft bit inverting
        ctrl[0] = '{mode: timer_group_pkg::MODE_ENC_EDGE, input_select: 3'h1, run: 1'b1,
            soft_dir: 1'b1, ext_dir_enable: 1'b1, default: 0};
        load(0, 16'h0000);
        enc(1'b0, 4);
        chk("enc count", 16'hFFFE, count[0]);
        chk("irq total", 16'h0007, 16'(irqs));
        chk("status", 16'h0005, 16'(status[0]));
        $display("encoder test done");
    endtask
    task automatic close_out();
        $display("checks %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        cyc(3);
        sys_rst = 1'b0;
        cyc(1);
        test_write();
        test_timer();
        test_gate();
        test_counter();
        test_encoder();
        close_out();
    end
endmodule // three_timer_group_tb
bind three_timer_group timer_group_asserts #(.NUM_TIMERS(NUM_TIMERS)) i_chk (.mclk(mclk),
    .sys_rst(sys_rst), .global_prescale_field(global_prescale_field), .ctrl(ctrl), .pins(pins),
    .count_wr(count_wr), .count_wdata(count_wdata), .status_clr(status_clr), .count(count),
    .status(status), .timer_irq(timer_irq));
